//--- hw/fwg_host.v
// host-side controller driving the flash pins for guarded writes and secured-sector access
// Function
// [RULE_01] protect verify read: id voltage, we high, a2 high, cs oe a7 a1 low
// [RULE_02] queried sector group comes from address lines 17 to 22
// [RULE_03] device starts in array read after power-up, no command needed
// [RULE_04] memory changes only after a full valid command sequence
// [RULE_05] secured region is 128 words; lock state on data bit 7
// [RULE_06] indicator bit one when factory locked, zero otherwise, fixed
// [RULE_07] after entry, first sector addresses read secured region
// [RULE_08] mapping lasts until exit sequence, power loss or hardware reset
// [RULE_09] factory parts hold serial number at words 0-7, rest unavailable
// [RULE_10] protected secured region refuses all program and erase forever
// [RULE_11] lock by three-cycle entry then in-system protect algorithm
// [RULE_12] host issues exit sequence before touching the rest of array
// [RULE_13] below lockout supply the device ignores every write
// [RULE_14] strobe pulses under about 5 ns never start a write
// [RULE_15] write needs cs and we low with oe high
// [RULE_16] power-up with cs we low, oe high: first we rise not accepted
// [RULE_17] wrong address, data or order returns device to array read
// [RULE_18] suspend b0 and resume 30 valid only during sector erase
// [RULE_19] address latched on later falling edge, data on earlier rise
// [RULE_20] either reset sequence returns the device to read state
// [RULE_21] reset command needed to leave identifier mode
// [RULE_22] one protect flag per sector group sources verify output
`timescale 1ns/1ns
`default_nettype none
`include "fwg_map.vh"
module fwg_host
(
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        op_valid,
	input  wire [3:0]  op_code,
	input  wire [22:0] op_addr,
	input  wire [15:0] op_wdata,
	input  wire        erase_active,
	input  wire        supply_ok,
	output reg         op_ready_r,
	output reg         op_done_r,
	output reg         op_refused_r,
	output reg  [15:0] op_rdata_r,
	output reg         sec_mapped_r,
	output reg         group_protected_r,
	output reg         lock_indicator_r,
	output reg  [22:0] flash_addr_r,
	output reg  [15:0] flash_dq_out_r,
	output reg         flash_dq_oe_n_r,
	input  wire [15:0] flash_dq_in,
	output reg         flash_ce_n_r,
	output reg         flash_we_n_r,
	output reg         flash_oe_n_r,
	output reg         elevated_id_voltage_r,
	output reg         flash_reset_n_r
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [6:0] ST_IDLE  = 7'h01;
	localparam [6:0] ST_FETCH = 7'h02;
	localparam [6:0] ST_SETUP = 7'h04;
	localparam [6:0] ST_PULSE = 7'h08;
	localparam [6:0] ST_HOLD  = 7'h10;
	localparam [6:0] ST_READ  = 7'h20;
	localparam [6:0] ST_DONE  = 7'h40;

	reg  [6:0]  state_r;
	reg  [3:0]  op_r;
	reg  [22:0] addr_r;
	reg  [15:0] wdata_r;
	reg  [2:0]  step_r;
	reg  [3:0]  cnt_r;
	reg         hw_read_r;
	wire [22:0] step_addr;
	wire [15:0] step_data;
	wire        step_last;

	// is this op a pure pin-level read that never writes a command
	function is_pin_read;
		input [3:0] op;
		begin
			is_pin_read = (op == `FWG_OP_READ) || (op == `FWG_OP_PROT_VER);
		end
	endfunction

	// refusal check, shared by acceptance and the done flags
	function op_illegal;
		input [3:0] op;
		input       erase;
		input       sup;
		begin
			op_illegal = (!sup && !is_pin_read(op)) // see [RULE_13]
				|| (((op == `FWG_OP_SUSPEND) || (op == `FWG_OP_RESUME)) && !erase); // see [RULE_18]
		end
	endfunction

	fwg_seq_rom u_rom
	(
		.core_clk    (core_clk),
		.op          (op_r),
		.step        (step_r),
		.user_addr   (addr_r),
		.user_data   (wdata_r),
		.step_addr_r (step_addr),
		.step_data_r (step_data),
		.step_last_r (step_last)
	);

	// ----------------------------------------------------------------
	// bus sequencer
	// ----------------------------------------------------------------
	// strobes are held for whole core cycles, far beyond any noise width,
	// so every write we make is a real one; oe stays high across writes
	always @(posedge core_clk)
	begin
		op_done_r    <= 1'b0;
		op_refused_r <= 1'b0;
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			op_r <= `FWG_OP_READ;
			addr_r <= 23'h000000;
			wdata_r <= 16'h0000;
			step_r <= 3'h0;
			cnt_r <= 4'h0;
			hw_read_r <= 1'b0;
			op_ready_r <= 1'b0;
			op_rdata_r <= 16'h0000;
			sec_mapped_r <= 1'b0; // see [RULE_08]
			group_protected_r <= 1'b0;
			lock_indicator_r <= 1'b0;
			flash_addr_r <= 23'h000000;
			flash_dq_out_r <= 16'h0000;
			flash_dq_oe_n_r <= 1'b1;
			flash_ce_n_r <= 1'b1;
			flash_we_n_r <= 1'b1; // see [RULE_16]
			flash_oe_n_r <= 1'b1;
			elevated_id_voltage_r <= 1'b0;
			flash_reset_n_r <= 1'b0; // device resets to array read, see [RULE_03]
		end
		else
		begin
			flash_reset_n_r <= 1'b1; // held high through the lock flow, see [RULE_11]
			case (state_r)
				ST_IDLE:
				begin
					op_ready_r <= 1'b1;
					if (op_valid && op_ready_r)
					begin
						op_ready_r <= 1'b0;
						if (op_illegal(op_code, erase_active, supply_ok))
						begin
							op_refused_r <= 1'b1;
							op_done_r <= 1'b1;
						end
						else
						begin
							op_r <= op_code;
							addr_r <= op_addr;
							wdata_r <= op_wdata;
							step_r <= 3'h0;
							hw_read_r <= is_pin_read(op_code);
							state_r <= ST_FETCH;
						end
					end
				end
				ST_FETCH:
					state_r <= hw_read_r ? ST_READ : ST_SETUP; // rom output valid next
				ST_SETUP:
				begin
					// address and data settle before the strobe falls, see [RULE_19]
					flash_addr_r <= step_addr;
					flash_dq_out_r <= step_data;
					flash_dq_oe_n_r <= 1'b0;
					flash_oe_n_r <= 1'b1; // see [RULE_15]
					flash_ce_n_r <= 1'b0;
					cnt_r <= `FWG_PULSE_CYC;
					state_r <= ST_PULSE;
				end
				ST_PULSE:
				begin
					flash_we_n_r <= 1'b0; // see [RULE_15]
					if (cnt_r == 4'h0)
					begin
						flash_we_n_r <= 1'b1; // data taken on this rise, see [RULE_19]
						state_r <= ST_HOLD;
					end
					else
						cnt_r <= cnt_r - 4'h1; // wide pulse clears glitch filter, see [RULE_14]
				end
				ST_HOLD:
				begin
					flash_ce_n_r <= 1'b1;
					flash_dq_oe_n_r <= 1'b1;
					if (step_last)
					begin
						// mapping mirror follows only complete sequences, see [RULE_04]
						if (op_r == `FWG_OP_ENTER_SEC)
							sec_mapped_r <= 1'b1; // see [RULE_07]
						// a reset command only returns the device to array read; the mapping
						// stays until the exit sequence or a hardware reset, see [RULE_20] see [RULE_21]
						if (op_r == `FWG_OP_EXIT_SEC)
							sec_mapped_r <= 1'b0; // see [RULE_08] see [RULE_12]
						state_r <= ST_DONE;
					end
					else
					begin
						step_r <= step_r + 3'h1;
						state_r <= ST_FETCH;
					end
				end
				ST_READ:
				begin
					// verify mode: id voltage, we and a2 high, a7 a1 low, see [RULE_01]
					flash_addr_r <= addr_r;
					if (op_r == `FWG_OP_PROT_VER)
					begin
						flash_addr_r[`FWG_STAT_SEL_BIT] <= 1'b1;
						flash_addr_r[`FWG_ID_SEL_BIT] <= 1'b0;
						flash_addr_r[`FWG_PMODE_BIT] <= 1'b0;
						elevated_id_voltage_r <= 1'b1;
					end
					flash_we_n_r <= 1'b1;
					flash_ce_n_r <= 1'b0;
					flash_oe_n_r <= 1'b0;
					flash_dq_oe_n_r <= 1'b1;
					if (cnt_r == `FWG_READ_CYC)
					begin
						op_rdata_r <= flash_dq_in;
						if (op_r == `FWG_OP_PROT_VER)
							group_protected_r <= flash_dq_in[0]; // see [RULE_02] see [RULE_22]
						else if (sec_mapped_r && (addr_r == 23'h000000))
							lock_indicator_r <= flash_dq_in[`FWG_LOCK_IND_BIT]; // see [RULE_05]
						cnt_r <= 4'h0;
						state_r <= ST_DONE;
					end
					else
						cnt_r <= cnt_r + 4'h1;
				end
				ST_DONE:
				begin
					flash_ce_n_r <= 1'b1;
					flash_oe_n_r <= 1'b1;
					elevated_id_voltage_r <= 1'b0;
					op_done_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- hw/fwg_map.vh
// constants for the flash write-guard host controller
`ifndef FWG_MAP_VH
`define FWG_MAP_VH
// ----------------------------------------------------------------
// pin timing, in 100 ns core cycles
// ----------------------------------------------------------------
`define FWG_CLK_NS        100
`define FWG_GLITCH_NS     5
`define FWG_GLITCH_CYC    (((`FWG_GLITCH_NS + `FWG_CLK_NS - 1) / `FWG_CLK_NS))
`define FWG_PULSE_CYC     4'h2
`define FWG_SETUP_CYC     4'h1
`define FWG_READ_CYC      4'h2
// ----------------------------------------------------------------
// command codes and unlock addresses (word mode)
// ----------------------------------------------------------------
`define FWG_UNLOCK1_ADDR  23'h000555
`define FWG_UNLOCK2_ADDR  23'h0002aa
`define FWG_UNLOCK1_DATA  16'h00aa
`define FWG_UNLOCK2_DATA  16'h0055
`define FWG_CMD_ENTER_SEC 16'h0088
`define FWG_CMD_AUTOSEL   16'h0090
`define FWG_CMD_EXIT_SEC  16'h0000
`define FWG_CMD_RESET     16'h00f0
`define FWG_CMD_PROGRAM   16'h00a0
`define FWG_CMD_SUSPEND   16'h00b0
`define FWG_CMD_RESUME    16'h0030
// ----------------------------------------------------------------
// operation codes at the user port
// ----------------------------------------------------------------
`define FWG_OP_READ       4'h0
`define FWG_OP_RESET      4'h1
`define FWG_OP_ENTER_SEC  4'h2
`define FWG_OP_EXIT_SEC   4'h3
`define FWG_OP_PROGRAM    4'h4
`define FWG_OP_PROT_VER   4'h5
`define FWG_OP_SUSPEND    4'h6
`define FWG_OP_RESUME     4'h7
`define FWG_OP_AUTOSEL    4'h8
// ----------------------------------------------------------------
// address field positions
// ----------------------------------------------------------------
`define FWG_ID_SEL_BIT    1
`define FWG_STAT_SEL_BIT  2
`define FWG_PMODE_BIT     7
`define FWG_GROUP_LSB     17
`define FWG_GROUP_MSB     22
`define FWG_SEC_WORDS     8'h80
`define FWG_ESN_LAST      23'h000007
`define FWG_LOCK_IND_BIT  7
`endif

//--- hw/fwg_seq_rom.v
// sequence step table: address and data for each bus cycle of a command
`timescale 1ns/1ns
`default_nettype none
`include "fwg_map.vh"
module fwg_seq_rom
(
	input  wire        core_clk,
	input  wire [3:0]  op,
	input  wire [2:0]  step,
	input  wire [22:0] user_addr,
	input  wire [15:0] user_data,
	output reg  [22:0] step_addr_r,
	output reg  [15:0] step_data_r,
	output reg         step_last_r
);
	// ----------------------------------------------------------------
	// registered lookup
	// ----------------------------------------------------------------
	// unlock prefix is shared; single-cycle commands skip it
	always @(posedge core_clk)
	begin
		step_last_r <= 1'b0;
		step_addr_r <= `FWG_UNLOCK1_ADDR;
		step_data_r <= `FWG_UNLOCK1_DATA;
		case (op)
			`FWG_OP_RESET, `FWG_OP_SUSPEND, `FWG_OP_RESUME:
			begin
				step_addr_r <= user_addr;
				step_data_r <= (op == `FWG_OP_RESET) ? `FWG_CMD_RESET :
					(op == `FWG_OP_SUSPEND) ? `FWG_CMD_SUSPEND : `FWG_CMD_RESUME;
				step_last_r <= 1'b1;
			end
			default:
			begin
				case (step)
					3'h0: ;
					3'h1:
					begin
						step_addr_r <= `FWG_UNLOCK2_ADDR;
						step_data_r <= `FWG_UNLOCK2_DATA;
					end
					3'h2:
					begin
						step_data_r <= (op == `FWG_OP_ENTER_SEC) ? `FWG_CMD_ENTER_SEC :
							(op == `FWG_OP_PROGRAM) ? `FWG_CMD_PROGRAM : `FWG_CMD_AUTOSEL;
						step_last_r <= (op == `FWG_OP_ENTER_SEC) || (op == `FWG_OP_PROT_VER)
							|| (op == `FWG_OP_AUTOSEL);
					end
					default:
					begin
						step_addr_r <= user_addr;
						step_data_r <= (op == `FWG_OP_EXIT_SEC) ? `FWG_CMD_EXIT_SEC : user_data;
						step_last_r <= 1'b1;
					end
				endcase
			end
		endcase
	end
endmodule
`default_nettype wire

//--- verification/flash_write_guard_secure_sector_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module flash_write_guard_secure_sector_test;
	logic        core_clk = 0, rst_n = 0, op_valid = 0, erase_active = 0, supply_ok = 1;
	logic [3:0]  op_code = 0;
	logic [22:0] op_addr = 0;
	logic [15:0] op_wdata = 0;
	logic [15:0] op_rdata_r, flash_dq_out_r, flash_dq_in, dev_dq;
	logic [22:0] flash_addr_r;
	logic        op_ready_r, op_done_r, op_refused_r, sec_mapped_r, group_protected_r;
	logic        lock_indicator_r, flash_dq_oe_n_r, flash_ce_n_r, flash_we_n_r, flash_oe_n_r;
	logic        elevated_id_voltage_r, flash_reset_n_r, refd;
	int          bad_count = 0, checked = 0, cyc = 0;
	fwg_host uut (.core_clk, .rst_n, .op_valid, .op_code, .op_addr, .op_wdata, .erase_active,
		.supply_ok, .op_ready_r, .op_done_r, .op_refused_r, .op_rdata_r, .sec_mapped_r,
		.group_protected_r, .lock_indicator_r, .flash_addr_r, .flash_dq_out_r,
		.flash_dq_oe_n_r, .flash_dq_in, .flash_ce_n_r, .flash_we_n_r, .flash_oe_n_r,
		.elevated_id_voltage_r, .flash_reset_n_r);
	fwg_flash_model dev (.ce_n(flash_ce_n_r), .we_n(flash_we_n_r), .oe_n(flash_oe_n_r),
		.id_v(elevated_id_voltage_r), .reset_n(flash_reset_n_r), .addr(flash_addr_r),
		.din(flash_dq_in), .dout(dev_dq));
	// the wire carries whoever drives it
	assign flash_dq_in = flash_dq_oe_n_r ? dev_dq : flash_dq_out_r;
	always #50 core_clk = ~core_clk;
	// a hang ends the run as a failure
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// hold the request until ready is seen, then wait for done within a bound
	task automatic op(input logic [3:0] c, input logic [22:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		op_code <= c;
		op_addr <= a;
		op_wdata <= d;
		op_valid <= 1'b1;
		do @(posedge core_clk); while (op_ready_r !== 1'b1);
		op_valid <= 1'b0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (op_done_r !== 1'b1 && n < 200);
		refd = op_refused_r;
		chk("done", {15'h0000, n < 200}, 16'h0001);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic t_array;
		op(4'h0, 23'h3, 16'h0);
		chk("read", op_rdata_r, 16'h1003);
		op(4'h4, 23'h5, 16'h00c3);
		op(4'h0, 23'h5, 16'h0);
		chk("program", op_rdata_r, 16'h00c3);
		supply_ok <= 1'b0;
		op(4'h4, 23'h6, 16'h0);
		chk("lockout", {15'h0000, refd}, 16'h0001);
		supply_ok <= 1'b1;
		op(4'h0, 23'h6, 16'h0);
		chk("kept", op_rdata_r, 16'h1006);
	endtask
	task automatic t_verify;
		op(4'h5, {6'h05, 17'h0}, 16'h0);
		chk("prot", op_rdata_r, 16'h0001);
		chk("flag", {15'h0000, group_protected_r}, 16'h0001);
		op(4'h5, {6'h06, 17'h0}, 16'h0);
		chk("unprot", op_rdata_r, 16'h0000);
	endtask
	// entry then program checks that the factory-locked secured region refuses writes
	task automatic t_secured;
		op(4'h2, 23'h0, 16'h0);
		chk("map", {15'h0000, sec_mapped_r}, 16'h0001);
		op(4'h0, 23'h0, 16'h0);
		chk("secword", op_rdata_r, 16'h2080);
		chk("ind", {15'h0000, lock_indicator_r}, 16'h0001);
		op(4'h4, 23'h1, 16'h0);
		op(4'h0, 23'h1, 16'h0);
		chk("otp", op_rdata_r, 16'h2001);
		op(4'h3, 23'h0, 16'h0);
		op(4'h0, 23'h0, 16'h0);
		chk("exit", op_rdata_r, 16'h1000);
		op(4'h2, 23'h0, 16'h0);
		op(4'h1, 23'h0, 16'h0);
		chk("rstcmd", {15'h0000, sec_mapped_r}, 16'h0001);
		op(4'h0, 23'h0, 16'h0);
		chk("rstsec", op_rdata_r, 16'h2080);
		do_reset;
		chk("rstmap", {15'h0000, sec_mapped_r}, 16'h0000);
		op(4'h0, 23'h0, 16'h0);
		chk("rstread", op_rdata_r, 16'h1000);
	endtask
	task automatic t_suspend;
		op(4'h6, 23'h0, 16'h0);
		chk("susp0", {15'h0000, refd}, 16'h0001);
		erase_active <= 1'b1;
		op(4'h6, 23'h0, 16'h0);
		chk("susp1", {15'h0000, refd}, 16'h0000);
		op(4'h7, 23'h0, 16'h0);
		chk("resume", {15'h0000, refd}, 16'h0000);
		erase_active <= 1'b0;
		op(4'h8, 23'h0, 16'h0);
		op(4'h0, 23'h3, 16'h0);
		chk("idmode", op_rdata_r, 16'h0a5a);
		op(4'h1, 23'h0, 16'h0);
		op(4'h0, 23'h3, 16'h0);
		chk("idexit", op_rdata_r, 16'h1003);
	endtask
	initial
	begin
		do_reset;
		t_array;
		t_verify;
		t_secured;
		t_suspend;
		report_and_stop;
	end
endmodule
`default_nettype wire

//--- verification/fwg_flash_model.sv
// behavioural flash device as seen at the host pins
`timescale 1ns/1ns
`default_nettype none
module fwg_flash_model
#(
	parameter FACTORY = 1'b1
)
(
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic        id_v,
	input wire logic        reset_n,
	input wire logic [22:0] addr,
	input wire logic [15:0] din,
	output logic     [15:0] dout
);
	logic [15:0] mem [0:15];
	logic [15:0] sec [0:15];
	logic        prot [0:63];
	logic [22:0] a_lat;
	logic [2:0]  st = 3'h0;
	logic        map = 1'b0;
	logic [15:0] last = 16'h0000;
	logic [15:0] rd;
	// identifier word shown while in identifier mode; the value is arbitrary
	localparam logic [15:0] ID_WORD = 16'h0a5a;
	// only the low address bits are stored: a small but honest array
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			mem[i] = 16'h1000 + 16'(i);
			sec[i] = 16'h2000 + 16'(i);
		end
		sec[0][7] = FACTORY;
		for (int i = 0; i < 64; i++)
			prot[i] = i == 5;
	end
	// address taken on the later falling strobe
	always @(negedge we_n or negedge ce_n)
		a_lat = addr;
	// data taken on the first rising strobe while the other is still low
	always @(posedge we_n or posedge ce_n)
		if (reset_n && oe_n && !(we_n && ce_n))
		begin
			if (st == 3'h3)
			begin
				if (!(map && a_lat[22:7] == 0))
					mem[a_lat[3:0]] = din;
				else if (!FACTORY)
					sec[a_lat[3:0]] = din;
				st = 3'h0;
			end
			else if (din == 16'h00f0)
				st = 3'h0;
			else if (st == 3'h4 && din == 16'h0000)
			begin
				map = 1'b0;
				st = 3'h0;
			end
			else if (st == 3'h0 && a_lat[10:0] == 11'h555 && din == 16'h00aa)
				st = 3'h1;
			else if (st == 3'h1 && a_lat[10:0] == 11'h2aa && din == 16'h0055)
				st = 3'h2;
			else if (st == 3'h2 && din == 16'h0088)
			begin
				map = 1'b1;
				st = 3'h0;
			end
			else if (st == 3'h2 && (din == 16'h0090 || din == 16'h00a0))
				st = din == 16'h0090 ? 3'h4 : 3'h3;
			else
				st = 3'h0;
		end
	// hardware reset restores normal mapping and read mode
	always @(negedge reset_n)
	begin
		st = 3'h0;
		map = 1'b0;
	end
	// protect status only with the full verify pin pattern, otherwise all ones while id voltage is high;
	// identifier mode hides the array until the next command word is written or reset_n falls
	assign rd = (id_v && we_n && addr[2] && !addr[1] && !addr[7])
		? {15'h0000, prot[addr[22:17]]}
		: id_v ? 16'hffff
		: (st == 3'h4) ? ID_WORD
		: (map && addr[22:7] == 0) ? sec[addr[3:0]] : mem[addr[3:0]];
	// a released bus shows the inverse of the last word, never a stale copy
	always @(posedge oe_n)
		last = rd;
	assign dout = (!ce_n && !oe_n) ? rd : ~last;
endmodule
`default_nettype wire

//--- verification/fwg_host_properties.sv
// pin and port timing checks for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module fwg_host_properties
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        op_valid,
	input wire logic [3:0]  op_code,
	input wire logic        erase_active,
	input wire logic        supply_ok,
	input wire logic        op_ready_r,
	input wire logic        op_refused_r,
	input wire logic        sec_mapped_r,
	input wire logic [22:0] flash_addr_r,
	input wire logic [15:0] flash_dq_out_r,
	input wire logic        flash_dq_oe_n_r,
	input wire logic        flash_ce_n_r,
	input wire logic        flash_we_n_r,
	input wire logic        flash_oe_n_r,
	input wire logic        elevated_id_voltage_r,
	input wire logic        flash_reset_n_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// reads and protect verify are the only ops that never write
	wire take = op_valid && op_ready_r;
	wire wr_op = op_code != 4'h0 && op_code != 4'h5;
	wire susp = op_code == 4'h6 || op_code == 4'h7;
	AST_WR_GATE: assert property (
		!flash_we_n_r |-> !flash_ce_n_r && flash_oe_n_r)
		else $error("we low outside a legal write");
	AST_RD_QUIET: assert property (
		!flash_oe_n_r |-> flash_dq_oe_n_r && flash_we_n_r)
		else $error("bus driven or we low while reading");
	AST_RST_PINS: assert property (
		!$past(rst_n) |-> flash_we_n_r && flash_ce_n_r && !flash_reset_n_r && !sec_mapped_r)
		else $error("pins not idle out of reset");
	AST_LOW_SUPPLY: assert property (
		take && !supply_ok && wr_op |-> ##[1:2] op_refused_r)
		else $error("write op run below lockout");
	AST_SUSP_REF: assert property (
		take && !erase_active && susp |-> ##[1:2] op_refused_r)
		else $error("suspend or resume sent with no erase");
	AST_LATCH_HOLD: assert property (
		!flash_we_n_r |-> $stable(flash_addr_r) && $stable(flash_dq_out_r) && !flash_dq_oe_n_r)
		else $error("address or data moved during write pulse");
	// the sequencer holds we low for two core cycles, far beyond any noise width
	AST_PULSE_LEN: assert property (
		$fell(flash_we_n_r) |-> !flash_we_n_r [*2] ##1 flash_we_n_r)
		else $error("write pulse not two cycles");
	AST_VERIFY_PINS: assert property (
		elevated_id_voltage_r && !flash_oe_n_r |-> flash_we_n_r && !flash_ce_n_r
		&& flash_addr_r[2] && !flash_addr_r[7] && !flash_addr_r[1])
		else $error("protect verify pin levels wrong");
endmodule
bind fwg_host fwg_host_properties chk (.core_clk, .rst_n, .op_valid, .op_code, .erase_active,
	.supply_ok, .op_ready_r, .op_refused_r, .sec_mapped_r, .flash_addr_r, .flash_dq_out_r,
	.flash_dq_oe_n_r, .flash_ce_n_r, .flash_we_n_r, .flash_oe_n_r, .elevated_id_voltage_r,
	.flash_reset_n_r);
`default_nettype wire
